// ==== hdl/cie_initiate_fmt.sv ====
// INITIATE request/response formatter with register port and interrupt
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Normal completion writes A412H to word 0
// - Word 1 holds address and connection reference
// - Word 2 holds maximum data unit length
// - Word 3 holds supported features
// - Word 4 holds profile supported features
// - Word 5 holds profile identifier
// - Word 6 holds source type and length
// - Word 7 holds destination type and length
// - Words after last defined read 0000H
// - Failure writes error code to word 0
// - Error E482H stores detail codes 2..4
// - Other errors store FFFFH in 2..4
module cie_initiate_fmt (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [cie_pkg::ADDR_W-1:0] i_addr,
   input wire logic [cie_pkg::WORD_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [cie_pkg::WORD_W-1:0] o_rdata,
   output logic o_irq,
   output logic o_busy,
   output logic o_slv_start,
   output logic [6:0] o_slv_addr,
   output logic [cie_pkg::WORD_W-1:0] o_slv_timeout,
   input wire logic i_slv_done,
   input wire logic i_slv_ok,
   input wire logic [cie_pkg::WORD_W-1:0] i_slv_err_code,
   input wire logic [cie_pkg::WORD_W-1:0] i_slv_detail1,
   input wire logic [cie_pkg::WORD_W-1:0] i_slv_detail2,
   input wire logic [cie_pkg::WORD_W-1:0] i_slv_detail3,
   input wire logic [7:0] i_slv_comm_ref,
   input wire logic [cie_pkg::WORD_W-1:0] i_slv_max_len,
   input wire logic [cie_pkg::WORD_W-1:0] i_slv_features,
   input wire logic [cie_pkg::WORD_W-1:0] i_slv_prof_features,
   input wire logic [cie_pkg::WORD_W-1:0] i_slv_prof_ident,
   input wire logic [cie_pkg::WORD_W-1:0] i_slv_src_type_len,
   input wire logic [cie_pkg::WORD_W-1:0] i_slv_dst_type_len
);
   import cie_pkg::*;

   cie_regs_s r;
   cie_regs_s next_r;

   // ****************************************************************
   // Address decode and detail fill helpers
   // ****************************************************************
   function automatic logic in_req(input logic [ADDR_W-1:0] a);
      in_req = (a[8:7] == REQ_BASE[8:7]);
   endfunction

   function automatic logic in_resp(input logic [ADDR_W-1:0] a);
      in_resp = (a[8:7] == RESP_BASE[8:7]);
   endfunction

   function automatic logic [WORD_W-1:0] detail_or_none(input logic [WORD_W-1:0] err,
                                                         input logic [WORD_W-1:0] det);
      detail_or_none = (err == ERR_DETAIL_CODE) ? det : NO_DETAIL;
   endfunction

   logic [EVT_W-1:0] set_evt;
   logic fmt_bad;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_r = r;
      set_evt = '0;
      fmt_bad = 1'b0;
      next_r.start = 1'b0;
      // Register writes
      if (i_wr) begin
         if (in_req(i_addr)) begin
            if (i_addr[6:0] < 7'(REQ_WORDS)) begin
               next_r.req[i_addr[3:0]] = i_wdata;
            end else if (i_wdata != EMPTY_WORD) begin
               fmt_bad = 1'b1;
            end
         end else if (i_addr == MASK_ADDR) begin
            next_r.mask = i_wdata[EVT_W-1:0];
         end
      end
      // Sequencer
      case (r.state)
         ST_IDLE: begin
            if (i_wr && i_addr == CTRL_ADDR && i_wdata[CTRL_START_BIT]) begin
               if (r.req[WORD_REQ_DST[3:0]][7:0] != DST_FIXED) begin
                  fmt_bad = 1'b1;
               end
               if (r.req[WORD_REQ_DST[3:0]][15:8] != DST_FIXED) begin
                  fmt_bad = 1'b1;
               end
               if (r.req[WORD_REF[3:0]][15:7] != '0 ||
                   r.req[WORD_REF[3:0]][6:0] > FDL_ADDR_MAX) begin
                  fmt_bad = 1'b1;
               end
               if (r.req[WORD_CODE[3:0]] != REQ_CODE) begin
                  fmt_bad = 1'b1;
               end
               next_r.slv_addr = r.req[WORD_REF[3:0]][6:0];
               next_r.slv_tmo = r.req[WORD_REQ_TMO[3:0]];
               next_r.start = 1'b1;
               next_r.busy = 1'b1;
               next_r.state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (i_slv_done) begin
               next_r.res_ok = i_slv_ok;
               next_r.res_err = i_slv_err_code;
               // Word 1 identical for both outcomes
               next_r.resp[WORD_REF[2:0]] = {i_slv_comm_ref, 1'b0, r.slv_addr};
               if (i_slv_ok) begin
                  next_r.resp[WORD_MAXLEN[2:0]] = i_slv_max_len;
                  next_r.resp[WORD_FEAT[2:0]] = i_slv_features;
                  next_r.resp[WORD_PFEAT[2:0]] = i_slv_prof_features;
                  next_r.resp[WORD_PID[2:0]] = i_slv_prof_ident;
                  next_r.resp[WORD_SRC[2:0]] = i_slv_src_type_len;
                  next_r.resp[WORD_DST[2:0]] = i_slv_dst_type_len;
               end else begin
                  next_r.resp[WORD_MAXLEN[2:0]] = detail_or_none(i_slv_err_code,
                                                                 i_slv_detail1);
                  next_r.resp[WORD_FEAT[2:0]] = detail_or_none(i_slv_err_code,
                                                               i_slv_detail2);
                  next_r.resp[WORD_PFEAT[2:0]] = detail_or_none(i_slv_err_code,
                                                                i_slv_detail3);
                  next_r.resp[WORD_PID[2:0]] = EMPTY_WORD;
                  next_r.resp[WORD_SRC[2:0]] = EMPTY_WORD;
                  next_r.resp[WORD_DST[2:0]] = EMPTY_WORD;
               end
               next_r.state = ST_CAPTURE;
            end
         end
         ST_CAPTURE: begin
            // Result code goes in last so word 0 marks a complete area
            next_r.resp[WORD_CODE[2:0]] = r.res_ok ? RESP_OK_CODE : r.res_err;
            next_r.state = ST_FINISH;
         end
         ST_FINISH: begin
            set_evt[ST_DONE_BIT] = 1'b1;
            set_evt[ST_FAIL_BIT] = ~r.res_ok;
            next_r.busy = 1'b0;
            next_r.state = ST_IDLE;
         end
         default: begin
            next_r.state = ST_IDLE;
         end
      endcase
      set_evt[ST_FMT_BIT] = fmt_bad;
      // Sticky events: read clears, a new event wins
      if (i_rd && i_addr == STATUS_ADDR) begin
         next_r.evt = set_evt;
      end else begin
         next_r.evt = r.evt | set_evt;
      end
      next_r.irq = |(next_r.evt & next_r.mask);
      // Read data, one cycle after the strobe
      next_r.rdata = EMPTY_WORD;
      if (i_rd) begin
         if (in_req(i_addr)) begin
            if (i_addr[6:0] < 7'(REQ_WORDS)) begin
               next_r.rdata = r.req[i_addr[3:0]];
            end
         end else if (in_resp(i_addr)) begin
            if (i_addr[6:0] < 7'(RESP_WORDS)) begin
               next_r.rdata = r.resp[i_addr[2:0]];
            end else begin
               next_r.rdata = EMPTY_WORD;
            end
         end else if (i_addr == STATUS_ADDR) begin
            next_r.rdata = {12'h000, r.busy, r.evt};
         end else if (i_addr == MASK_ADDR) begin
            next_r.rdata = {13'h0000, r.mask};
         end
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         r.state <= ST_IDLE;
         r.req <= '0;
         r.resp <= '0;
         r.res_ok <= 1'b0;
         r.res_err <= EMPTY_WORD;
         r.evt <= EVT_RESET;
         r.mask <= MASK_RESET;
         r.start <= 1'b0;
         r.busy <= 1'b0;
         r.irq <= 1'b0;
         r.slv_addr <= 7'h00;
         r.slv_tmo <= EMPTY_WORD;
         r.rdata <= EMPTY_WORD;
      end else begin
         r <= next_r;
      end
   end

   assign o_rdata = r.rdata;
   assign o_irq = r.irq;
   assign o_busy = r.busy;
   assign o_slv_start = r.start;
   assign o_slv_addr = r.slv_addr;
   assign o_slv_timeout = r.slv_tmo;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   sequence s_done_any;
      r.state == ST_WAIT && i_slv_done;
   endsequence

   sequence s_done_ok;
      r.state == ST_WAIT && i_slv_done && i_slv_ok;
   endsequence

   sequence s_done_fail;
      r.state == ST_WAIT && i_slv_done && !i_slv_ok;
   endsequence

   sequence s_start_taken;
      r.state == ST_IDLE && i_wr && i_addr == CTRL_ADDR && i_wdata[CTRL_START_BIT];
   endsequence

   // Done flag stays low through both fill cycles, then rises
   sequence s_done_late;
      !r.evt[ST_DONE_BIT] [*2] ##1 r.evt[ST_DONE_BIT];
   endsequence

   // ****************************************************************
   // Response area
   // ****************************************************************
   a_ok_code_word: assert property (s_done_ok |=> ##1 r.resp[0] == RESP_OK_CODE)
      else $error("normal result code wrong");

   a_ref_word_fill: assert property (s_done_any |=>
      r.resp[1] == {$past(i_slv_comm_ref), 1'b0, r.slv_addr})
      else $error("address/reference word wrong");

   a_ok_data_words: assert property (s_done_ok |=>
      r.resp[2] == $past(i_slv_max_len) && r.resp[3] == $past(i_slv_features) &&
      r.resp[4] == $past(i_slv_prof_features) && r.resp[5] == $past(i_slv_prof_ident))
      else $error("normal data words wrong");

   a_ok_type_words: assert property (s_done_ok |=>
      r.resp[6] == $past(i_slv_src_type_len) && r.resp[7] == $past(i_slv_dst_type_len))
      else $error("type/length words wrong");

   a_fail_err_code: assert property (s_done_fail |=>
      ##1 r.resp[0] == $past(i_slv_err_code, 2))
      else $error("error code not stored");

   a_fail_detail_codes: assert property ((s_done_fail and
      i_slv_err_code == ERR_DETAIL_CODE) |=> r.resp[2] == $past(i_slv_detail1) &&
      r.resp[3] == $past(i_slv_detail2) && r.resp[4] == $past(i_slv_detail3))
      else $error("detail codes not stored");

   a_fail_no_detail: assert property ((s_done_fail and
      i_slv_err_code != ERR_DETAIL_CODE) |=> r.resp[2] == NO_DETAIL &&
      r.resp[3] == NO_DETAIL && r.resp[4] == NO_DETAIL)
      else $error("missing FFFF fill");

   a_fail_zero_fill: assert property (s_done_fail |=> r.resp[5] == EMPTY_WORD &&
      r.resp[6] == EMPTY_WORD && r.resp[7] == EMPTY_WORD)
      else $error("empty words not zero");

   a_code_word_last: assert property (s_done_any |=> $stable(r.resp[0]))
      else $error("result code written too early");

   a_resp_readback: assert property (i_rd && in_resp(i_addr) && i_addr[6:0] < 7'(RESP_WORDS)
      |=> o_rdata == $past(r.resp[i_addr[2:0]]))
      else $error("response word read wrong");

   a_resp_tail_zero: assert property (i_rd && in_resp(i_addr) &&
      i_addr[6:0] >= 7'(RESP_WORDS) |=> o_rdata == EMPTY_WORD)
      else $error("response tail not zero");

   // ****************************************************************
   // Register port
   // ****************************************************************
   a_req_store: assert property (i_wr && in_req(i_addr) && i_addr[6:0] < 7'(REQ_WORDS)
      |=> r.req[$past(i_addr[3:0])] == $past(i_wdata))
      else $error("request word not stored");

   a_req_readback: assert property (i_rd && in_req(i_addr) && i_addr[6:0] < 7'(REQ_WORDS)
      |=> o_rdata == $past(r.req[i_addr[3:0]]))
      else $error("request word read wrong");

   a_req_tail_zero: assert property (i_rd && in_req(i_addr) &&
      i_addr[6:0] >= 7'(REQ_WORDS) |=> o_rdata == EMPTY_WORD)
      else $error("request tail not zero");

   a_req_tail_warn: assert property (i_wr && in_req(i_addr) &&
      i_addr[6:0] >= 7'(REQ_WORDS) && i_wdata != EMPTY_WORD |=> r.evt[ST_FMT_BIT])
      else $error("tail write not flagged");

   a_mask_write: assert property (i_wr && i_addr == MASK_ADDR
      |=> r.mask == $past(i_wdata[EVT_W-1:0]))
      else $error("mask not written");

   a_mask_readback: assert property (i_rd && i_addr == MASK_ADDR
      |=> o_rdata == {13'h0000, $past(r.mask)})
      else $error("mask read wrong");

   a_status_readback: assert property (i_rd && i_addr == STATUS_ADDR
      |=> o_rdata == {12'h000, $past(r.busy), $past(r.evt)})
      else $error("status read wrong");

   a_rdata_one_cycle: assert property (!i_rd |=> o_rdata == EMPTY_WORD)
      else $error("read data outside its cycle");

   a_status_read_clear: assert property (i_rd && i_addr == STATUS_ADDR && r.state != ST_FINISH
      |=> r.evt == EVT_RESET)
      else $error("status read did not clear");

   a_status_sticky: assert property (r.evt[ST_DONE_BIT] && !(i_rd && i_addr == STATUS_ADDR)
      |=> r.evt[ST_DONE_BIT])
      else $error("done flag lost");

   a_irq_follows_evt: assert property (o_irq == |(r.evt & r.mask))
      else $error("irq mismatch");

   // ****************************************************************
   // Sequencer and events
   // ****************************************************************
   a_start_one_pulse: assert property (o_slv_start |=> !o_slv_start && o_busy)
      else $error("start pulse not single");

   a_start_takes_req: assert property (s_start_taken |=> o_slv_start &&
      o_slv_timeout == $past(r.req[WORD_REQ_TMO[3:0]]) &&
      o_slv_addr == $past(r.req[WORD_REF[3:0]][6:0]))
      else $error("start did not copy request");

   a_start_busy_drop: assert property (r.state != ST_IDLE && i_wr && i_addr == CTRL_ADDR
      |=> !o_slv_start)
      else $error("start taken while busy");

   a_idle_not_busy: assert property (r.state == ST_IDLE |-> !o_busy)
      else $error("busy while idle");

   a_dst_type_warn: assert property ((s_start_taken and
      r.req[WORD_REQ_DST[3:0]][7:0] != DST_FIXED) |=> r.evt[ST_FMT_BIT])
      else $error("destination type not flagged");

   a_dst_len_warn: assert property ((s_start_taken and
      r.req[WORD_REQ_DST[3:0]][15:8] != DST_FIXED) |=> r.evt[ST_FMT_BIT])
      else $error("destination length not flagged");

   a_addr_range_warn: assert property ((s_start_taken and
      r.req[WORD_REF[3:0]] > {9'h000, FDL_ADDR_MAX}) |=> r.evt[ST_FMT_BIT])
      else $error("target address not flagged");

   a_busy_until_done: assert property (s_done_any |=> o_busy [*2] ##1 !o_busy)
      else $error("busy dropped at wrong time");

   a_done_after_fill: assert property (s_done_any |=> s_done_late)
      else $error("done flagged at wrong time");

   a_fail_flag_late: assert property (s_done_fail |=> ##2 r.evt[ST_FAIL_BIT])
      else $error("fail flag not set");

endmodule

`default_nettype wire

// ==== hdl/cie_pkg.sv ====
// Constants, state encoding and state record of the INITIATE exchange formatter
package cie_pkg;
   // ****************************************************************
   // Bus geometry
   // ****************************************************************
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned REQ_WORDS = 9;
   localparam int unsigned RESP_WORDS = 8;
   // ****************************************************************
   // Register map (word index)
   // ****************************************************************
   localparam logic [8:0] REQ_BASE = 9'h000;
   localparam logic [8:0] RESP_BASE = 9'h080;
   localparam logic [8:0] CTRL_ADDR = 9'h100;
   localparam logic [8:0] STATUS_ADDR = 9'h101;
   localparam logic [8:0] MASK_ADDR = 9'h102;
   localparam logic [6:0] WORD_CODE = 7'h00;
   localparam logic [6:0] WORD_REF = 7'h01;
   localparam logic [6:0] WORD_MAXLEN = 7'h02;
   localparam logic [6:0] WORD_FEAT = 7'h03;
   localparam logic [6:0] WORD_PFEAT = 7'h04;
   localparam logic [6:0] WORD_PID = 7'h05;
   localparam logic [6:0] WORD_SRC = 7'h06;
   localparam logic [6:0] WORD_DST = 7'h07;
   localparam logic [6:0] WORD_REQ_TMO = 7'h02;
   localparam logic [6:0] WORD_REQ_DST = 7'h08;
   localparam logic [6:0] WORD_LAST = 7'h7F;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int unsigned CTRL_START_BIT = 0;
   localparam int unsigned ST_DONE_BIT = 0;
   localparam int unsigned ST_FAIL_BIT = 1;
   localparam int unsigned ST_FMT_BIT = 2;
   localparam int unsigned ST_BUSY_BIT = 3;
   localparam int unsigned EVT_W = 3;
   // ****************************************************************
   // Codes and values
   // ****************************************************************
   localparam logic [15:0] REQ_CODE = 16'h1412;
   localparam logic [15:0] RESP_OK_CODE = 16'hA412;
   localparam logic [15:0] ERR_DETAIL_CODE = 16'hE482;
   localparam logic [15:0] NO_DETAIL = 16'hFFFF;
   localparam logic [15:0] EMPTY_WORD = 16'h0000;
   localparam logic [7:0] DST_FIXED = 8'h00;
   localparam logic [6:0] FDL_ADDR_MAX = 7'h7D;
   localparam logic [2:0] EVT_RESET = 3'h0;
   localparam logic [2:0] MASK_RESET = 3'h0;
   // ****************************************************************
   // State
   // ****************************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CAPTURE, ST_FINISH} cie_state_e;
   typedef struct packed {
      cie_state_e state;
      logic [REQ_WORDS-1:0][WORD_W-1:0] req;
      logic [RESP_WORDS-1:0][WORD_W-1:0] resp;
      logic res_ok;
      logic [WORD_W-1:0] res_err;
      logic [EVT_W-1:0] evt;
      logic [EVT_W-1:0] mask;
      logic start;
      logic busy;
      logic irq;
      logic [6:0] slv_addr;
      logic [WORD_W-1:0] slv_tmo;
      logic [WORD_W-1:0] rdata;
   } cie_regs_s;
endpackage

// ==== test/cie_slave_model.sv ====
// Behavioural far-side slave that answers INITIATE requests
`timescale 1ns/1ns
`default_nettype none
module cie_slave_model #(
   parameter logic [8:0][15:0] P_VALS = '0
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic [6:0] i_addr,
   input wire logic i_ok_cfg,
   input wire logic [15:0] i_err_cfg,
   input wire logic [7:0] i_delay,
   output logic o_done,
   output logic o_ok,
   output logic [15:0] o_err,
   output logic [7:0] o_ref,
   output logic [8:0][15:0] o_f
);
   logic [7:0] cnt;
   logic [6:0] addr_q;
   logic [15:0] junk;
   // ****************************************************************
   // Answer after a programmable delay
   // ****************************************************************
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         cnt <= 8'h00;
         o_done <= 1'b0;
         junk <= 16'h0000;
         addr_q <= 7'h00;
      end else begin
         junk <= ~junk ^ 16'h1357;
         o_done <= (cnt == 8'h01);
         if (i_start) begin
            cnt <= i_delay;
            addr_q <= i_addr;
         end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
   // Result lines other than o_ok carry a changing pattern outside the done pulse; o_ok holds 0 there
   assign o_ok = o_done ? i_ok_cfg : junk[0];
   assign o_err = o_done ? i_err_cfg : junk;
   assign o_ref = o_done ? {1'b0, addr_q} : junk[7:0];
   assign o_f = o_done ? P_VALS : {9{junk}};
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the INITIATE formatter
`timescale 1ns/1ns
`default_nettype none
module tb;
   import cie_pkg::*;
   localparam logic [8:0][15:0] VALS = {16'hD003, 16'hD002, 16'hD001, 16'h0403, 16'h0201,
      16'h1234, 16'h0002, 16'h0001, 16'h00F0};
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [8:0] i_addr = 9'h000;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic ok_cfg = 1'b1;
   logic [15:0] err_cfg = 16'h0000;
   logic [7:0] delay = 8'h03;
   logic [15:0] o_rdata, o_slv_timeout, err;
   logic o_irq, o_busy, o_slv_start, done, ok;
   logic [6:0] o_slv_addr;
   logic [7:0] cref;
   logic [8:0][15:0] f;
   int n_fail = 0;
   int samples_checked = 0;
   always #25 i_ref_clk = ~i_ref_clk;
   cie_initiate_fmt u_cie_initiate_fmt (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
      .o_busy(o_busy), .o_slv_start(o_slv_start), .o_slv_addr(o_slv_addr),
      .o_slv_timeout(o_slv_timeout), .i_slv_done(done), .i_slv_ok(ok), .i_slv_err_code(err),
      .i_slv_detail1(f[6]), .i_slv_detail2(f[7]), .i_slv_detail3(f[8]), .i_slv_comm_ref(cref),
      .i_slv_max_len(f[0]), .i_slv_features(f[1]), .i_slv_prof_features(f[2]),
      .i_slv_prof_ident(f[3]), .i_slv_src_type_len(f[4]), .i_slv_dst_type_len(f[5]));
   cie_slave_model #(.P_VALS(VALS)) u_cie_slave_model (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
      .i_start(o_slv_start), .i_addr(o_slv_addr), .i_ok_cfg(ok_cfg), .i_err_cfg(err_cfg),
      .i_delay(delay), .o_done(done), .o_ok(ok), .o_err(err), .o_ref(cref), .o_f(f));
   // ****************************************************************
   // Access tasks
   // ****************************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [8:0] a, input logic [15:0] exp);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1;
      check(o_rdata, exp);
   endtask
   // One complete exchange with response area readback
   task automatic op(input logic okv, input logic [15:0] e, input logic [6:0] a,
                     input logic [15:0] tmo, input logic irqv);
      logic [15:0] w;
      int k;
      ok_cfg <= okv;
      err_cfg <= e;
      wr(REQ_BASE, REQ_CODE);
      wr(REQ_BASE + 9'h001, {9'h000, a});
      wr(REQ_BASE + 9'h002, tmo);
      wr(REQ_BASE + 9'h008, EMPTY_WORD);
      wr(CTRL_ADDR, 16'h0001);
      #1;
      check({9'h000, o_slv_addr}, {9'h000, a});
      check(o_slv_timeout, tmo);
      k = 0;
      while (o_busy === 1'b1 && k < 300) begin
         @(posedge i_ref_clk);
         #1;
         k++;
      end
      check({15'h0000, o_busy}, 16'h0000);
      check({15'h0000, o_irq}, {15'h0000, irqv});
      rd(STATUS_ADDR, okv ? 16'h0001 : 16'h0003);
      @(posedge i_ref_clk);
      #1;
      check({15'h0000, o_irq}, 16'h0000);
      rd(RESP_BASE, okv ? RESP_OK_CODE : e);
      rd(RESP_BASE + 9'h001, {1'b0, a, 1'b0, a});
      for (int i = 2; i < 8; i++) begin
         w = okv ? VALS[i-2] : (i > 4) ? EMPTY_WORD :
            (e == ERR_DETAIL_CODE) ? VALS[i+4] : NO_DETAIL;
         rd(RESP_BASE + 9'(i), w);
      end
      rd(RESP_BASE + 9'h008, EMPTY_WORD);
      rd(RESP_BASE + 9'h07F, EMPTY_WORD);
   endtask
   task automatic summarize();
      $display("comparisons=%0d mismatches=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      repeat (5) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      rd(MASK_ADDR, 16'h0000);
      rd(STATUS_ADDR, 16'h0000);
      wr(MASK_ADDR, 16'h0007);
      rd(MASK_ADDR, 16'h0007);
      op(1'b1, 16'h0000, 7'h7D, 16'hFFFF, 1'b1);
      delay <= 8'h01;
      op(1'b0, ERR_DETAIL_CODE, 7'h00, 16'h0000, 1'b1);
      delay <= 8'h20;
      op(1'b0, 16'hE400, 7'h12, 16'h0001, 1'b1);
      wr(MASK_ADDR, 16'h0000);
      op(1'b1, 16'h0000, 7'h05, 16'h0064, 1'b0);
      wr(REQ_BASE + 9'h009, 16'h0001);
      rd(REQ_BASE + 9'h009, EMPTY_WORD);
      rd(STATUS_ADDR, 16'h0004);
      // Bad destination bytes still run; a start while busy is dropped
      wr(REQ_BASE + 9'h008, 16'h0101);
      wr(CTRL_ADDR, 16'h0001);
      wr(CTRL_ADDR, 16'h0001);
      repeat (60) @(posedge i_ref_clk);
      rd(STATUS_ADDR, 16'h0005);
      summarize();
   end
   initial begin
      #2000000;
      n_fail++;
      summarize();
   end
endmodule
`default_nettype wire
